// >>> verilog/open_detect_pkg.sv
// Purpose: shared constants and types for the open-wire detect control
// Assumes: 16-bit register port at word offsets, one clock
// Notes: tap vector order is taps 0..15, then 16, 16 mid, then 17
package open_detect_pkg;

  // register offsets
  localparam logic [7:0] select_low_addr = 8'h19;
  localparam logic [7:0] select_high_addr = 8'h1a;
  localparam logic [7:0] enable_ctrl_addr = 8'h1b;

  // widths and field layout
  localparam int reg_width = 16;
  localparam int addr_width = 8;
  localparam int low_tap_count = 16;
  localparam int high_tap_count = 3;
  localparam int tap_count = low_tap_count + high_tap_count;
  localparam int source_tap_count = 2;
  localparam int sink_tap_count = tap_count - source_tap_count;
  localparam int master_enable_pos = 0;
  localparam int top_tap_pos = 2;

  // reset values
  localparam logic [15:0] select_low_rst = 16'h0000;
  localparam logic [2:0] select_high_rst = 3'h0;
  localparam logic master_enable_rst = 1'b0;
  localparam logic [15:0] rdata_rst = 16'h0000;

  // power modes reported by the mode controller
  typedef enum logic [1:0] {
    mode_active,
    mode_standby,
    mode_sleep,
    mode_shutdown
  } power_mode_e;

  // register write or read request
  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    logic [15:0] wdata;
  } reg_req_s;

  // state of the control block
  typedef struct packed {
    logic [15:0] tap_select_lower;
    logic [2:0] tap_select_upper;
    logic open_detect_master_enable;
    logic [15:0] rdata;
    logic rvalid;
  } ctrl_state_s;

  // state of the current drive stage
  typedef struct packed {
    logic [1:0] source_on;
    logic [16:0] sink_on;
    logic drive_any;
  } drive_state_s;

endpackage : open_detect_pkg

// >>> verilog/tap_current_drive.sv
// Purpose: registered enables for the tap test current source and sinks
// Assumes: select and enable come from logic on the same clock
// Notes: outputs are flops so the analog switches never see glitches
`timescale 1ns/10ps
module tap_current_drive #(
  parameter int n_taps = 19,
  parameter int n_source = 2
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // control
  input wire logic master_enable,
  input wire logic mode_allows,
  input wire logic [n_taps-1:0] tap_select,
  // current switch enables
  output logic [n_source-1:0] source_on,
  output logic [n_taps-n_source-1:0] sink_on,
  output logic drive_any
);

  logic [n_source-1:0] source_q;
  logic [n_taps-n_source-1:0] sink_q;
  logic any_q;
  logic [n_taps-1:0] gated;

  // current flows only with master enable, own select bit and a legal mode
  assign gated = (master_enable && mode_allows) ? tap_select : '0;

  // lowest taps push outward, the rest pull inward, all at once
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      source_q <= '0;
      sink_q <= '0;
      any_q <= 1'b0;
    end else begin
      source_q <= gated[n_source-1:0];
      sink_q <= gated[n_taps-1:n_source];
      any_q <= |gated;
    end
  end

  assign source_on = source_q;
  assign sink_on = sink_q;
  assign drive_any = any_q;

endmodule : tap_current_drive

// >>> verilog/open_detect_ctrl.sv
// Purpose: register file and current steering for open-wire detection
// Assumes: register port driven by the serial front end on ref_clk
// Notes: the host sequences the whole measurement; this block only steers
`timescale 1ns/10ps
module open_detect_ctrl (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // power mode of the device
  input wire open_detect_pkg::power_mode_e power_mode,
  // register port
  input wire open_detect_pkg::reg_req_s reg_req,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  // test current switch enables
  output logic [1:0] source_on,
  output logic [16:0] sink_on,
  output logic drive_any,
  // register contents seen by other logic
  output logic master_enable,
  output logic [18:0] tap_select
);

  open_detect_pkg::ctrl_state_s state_q;
  open_detect_pkg::ctrl_state_s state_d;
  logic mode_allows;
  logic [18:0] tap_vector;

  // address match, shared by the write and the read path
  function automatic logic addr_is(input logic [7:0] addr,
                                   input logic [7:0] target);
    addr_is = (addr == target);
  endfunction : addr_is

  // readback value for one offset; unmapped offsets and reserved bits are 0
  function automatic logic [15:0] read_value(
      input logic [7:0] addr,
      input open_detect_pkg::ctrl_state_s st);
    read_value = open_detect_pkg::rdata_rst;
    if (addr_is(addr, open_detect_pkg::select_low_addr)) begin
      read_value = st.tap_select_lower;
    end else if (addr_is(addr, open_detect_pkg::select_high_addr)) begin
      read_value = {13'h0000, st.tap_select_upper};
    end else if (addr_is(addr, open_detect_pkg::enable_ctrl_addr)) begin
      read_value = {15'h0000, st.open_detect_master_enable};
    end
  endfunction : read_value

  // detection may run only in active and standby/low power
  always_comb begin
    case (power_mode)
      open_detect_pkg::mode_active: mode_allows = 1'b1;
      open_detect_pkg::mode_standby: mode_allows = 1'b1;
      open_detect_pkg::mode_sleep: mode_allows = 1'b0;
      open_detect_pkg::mode_shutdown: mode_allows = 1'b0;
      default: mode_allows = 1'b0;
    endcase
  end

  // register writes and read answers
  always_comb begin
    state_d = state_q;
    state_d.rvalid = 1'b0;
    if (reg_req.wr_en) begin
      if (addr_is(reg_req.addr, open_detect_pkg::select_low_addr)) begin
        state_d.tap_select_lower = reg_req.wdata;
      end
      if (addr_is(reg_req.addr, open_detect_pkg::select_high_addr)) begin
        // only taps 16, 16 mid and top exist; upper bits are dropped
        state_d.tap_select_upper =
          reg_req.wdata[open_detect_pkg::top_tap_pos:0];
      end
      if (addr_is(reg_req.addr, open_detect_pkg::enable_ctrl_addr)) begin
        state_d.open_detect_master_enable =
          reg_req.wdata[open_detect_pkg::master_enable_pos];
      end
    end
    // a read in the same cycle as a write returns the old contents
    if (reg_req.rd_en) begin
      state_d.rdata = read_value(reg_req.addr, state_q);
      state_d.rvalid = 1'b1;
    end
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q.tap_select_lower <= open_detect_pkg::select_low_rst;
      state_q.tap_select_upper <= open_detect_pkg::select_high_rst;
      state_q.open_detect_master_enable <=
        open_detect_pkg::master_enable_rst;
      state_q.rdata <= open_detect_pkg::rdata_rst;
      state_q.rvalid <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  // bits 0..16 are taps 0..16, bit 17 is 16 mid, bit 18 is 17; selection bits keep their value when
  // the mode forbids driving, so resuming needs no rewrite
  assign tap_vector = {state_q.tap_select_upper,
                       state_q.tap_select_lower};

  // selection survives a disable; the drive stage gates it instead, so a
  // host that clears enable first still stops the current on the edge after the enable flop clears
  tap_current_drive #(
    .n_taps(open_detect_pkg::tap_count),
    .n_source(open_detect_pkg::source_tap_count)
  ) u_drive (
    .ref_clk(ref_clk),
    .rst(rst),
    .master_enable(state_q.open_detect_master_enable),
    .mode_allows(mode_allows),
    .tap_select(tap_vector),
    .source_on(source_on),
    .sink_on(sink_on),
    .drive_any(drive_any)
  );

  // outputs straight from the state flops
  assign reg_rdata = state_q.rdata;
  assign reg_rvalid = state_q.rvalid;
  assign master_enable = state_q.open_detect_master_enable;
  assign tap_select = tap_vector;

endmodule : open_detect_ctrl

// >>> sim/open_detect_monitor.sv
// Purpose: port checks for the open-wire detect control
// Assumes: drive outputs trail the register outputs by one cycle
// Notes: the first edge after reset is skipped so $past sees clean state
`timescale 1ns/10ps
module open_detect_monitor (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // inputs
  input wire open_detect_pkg::power_mode_e power_mode,
  input wire open_detect_pkg::reg_req_s reg_req,
  // outputs
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic [1:0] source_on,
  input wire logic [16:0] sink_on,
  input wire logic drive_any,
  input wire logic master_enable,
  input wire logic [18:0] tap_select
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // currents are legal only when enabled in a live power mode
  wire logic live = master_enable && power_mode inside
    {open_detect_pkg::mode_active, open_detect_pkg::mode_standby};
  sequence wr_to(logic [7:0] a);
    reg_req.wr_en && reg_req.addr == a;
  endsequence
  sequence rd_low;
    reg_req.rd_en && reg_req.addr == open_detect_pkg::select_low_addr;
  endsequence
  src_drive_a: assert property (
    !$past(rst) |-> source_on == ($past(tap_select[1:0]) & {2{$past(live)}}))
    else $error("source enables wrong");
  sink_drive_a: assert property (
    !$past(rst) |-> sink_on == ($past(tap_select[18:2]) & {17{$past(live)}}))
    else $error("sink enables wrong");
  any_drive_a: assert property (
    drive_any == (|source_on || |sink_on)) else $error("drive_any wrong");
  sleep_off_a: assert property (
    !live [*2] |-> !drive_any) else $error("current in dead mode");
  en_write_a: assert property (
    wr_to(open_detect_pkg::enable_ctrl_addr) |=>
    master_enable == $past(reg_req.wdata[0])) else $error("enable write lost");
  low_write_a: assert property (
    wr_to(open_detect_pkg::select_low_addr) |=>
    tap_select[15:0] == $past(reg_req.wdata)) else $error("low select lost");
  high_write_a: assert property (
    wr_to(open_detect_pkg::select_high_addr) |=>
    tap_select[18:16] == $past(reg_req.wdata[2:0])) else $error("high lost");
  rd_answer_a: assert property (
    rd_low |=> reg_rvalid && reg_rdata == $past(tap_select[15:0]))
    else $error("low select read wrong");
endmodule : open_detect_monitor

// >>> sim/open_detect_host.sv
// Purpose: host controller model driving the register port
// Assumes: one request per call, launched 1 ns after the clock edge
// Notes: latency is cycles standing in for 100 ms per microfarad
`timescale 1ns/10ps
module open_detect_host #(
  parameter int latency_cycles = 20
) (
  // clock
  input wire logic ref_clk,
  // register port toward the device
  output open_detect_pkg::reg_req_s reg_req,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial reg_req = '0;
  // strobe held over exactly one sampling edge
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    #1 reg_req = '{1'b1, 1'b0, a, d};
    @(posedge ref_clk);
    #1 reg_req.wr_en = 1'b0;
  endtask : wr
  // answer is taken once the edge after the strobe has landed
  task automatic rd(input logic [7:0] a, output logic [15:0] d,
                    output logic v);
    @(posedge ref_clk);
    #1 reg_req = '{1'b0, 1'b1, a, 16'h0000};
    @(posedge ref_clk);
    #1 reg_req.rd_en = 1'b0;
    d = reg_rdata;
    v = reg_rvalid;
  endtask : rd
  // host verdict on one cell reading pair, in millivolts; the lowest cell
  // judges its second tap by a rise, every other case by a drop
  function automatic logic wire_open(input int before_mv, input int after_mv,
                                     input logic rise, input int lim_mv);
    int diff;
    diff = rise ? after_mv - before_mv : before_mv - after_mv;
    wire_open = diff >= lim_mv;
  endfunction : wire_open
  // enable first, select, wait, then clear selects before enable
  task automatic run_check(input logic [18:0] sel);
    wr(8'h1b, 16'h0001);
    wr(8'h19, sel[15:0]);
    wr(8'h1a, {13'h0000, sel[18:16]});
    repeat (latency_cycles) @(posedge ref_clk);
    wr(8'h19, 16'h0000);
    wr(8'h1a, 16'h0000);
    wr(8'h1b, 16'h0000);
  endtask : run_check
endmodule : open_detect_host

// >>> sim/testbench.sv
// Purpose: directed register-level test of the open-wire detect control
// Assumes: reset values of all registers are zero
// Notes: drive outputs are checked one edge after the last write lands
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin \
  err_count++; $display("mismatch %s exp %h got %h", nm, ex, got); end end
module testbench;
  logic ref_clk = 0;
  logic rst = 1;
  open_detect_pkg::power_mode_e power_mode = open_detect_pkg::mode_active;
  open_detect_pkg::reg_req_s reg_req;
  logic [15:0] reg_rdata, d;
  logic reg_rvalid, drive_any, master_enable, v;
  logic [1:0] source_on;
  logic [16:0] sink_on;
  logic [18:0] tap_select, t;
  int err_count = 0, cmp_count = 0, cyc = 0;
  always #2 ref_clk = ~ref_clk;
  // hang guard far above the roughly 160 cycles needed
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      stop_test();
    end
  end
  open_detect_ctrl u_open_detect_ctrl (.*);
  open_detect_host u_host (.*);
  task automatic stop_test;
    $display("errors %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  task automatic rchk(input logic [7:0] a, input logic [15:0] e);
    u_host.rd(a, d, v);
    `CHK("rvalid", 1'b1, v)
    `CHK("rdata", e, d)
  endtask : rchk
  task automatic dchk(input logic [18:0] e);
    @(posedge ref_clk);
    #1 `CHK("drive", e, {sink_on, source_on})
    `CHK("drive_any", |e, drive_any)
  endtask : dchk
  initial begin
    repeat (5) @(posedge ref_clk);
    #1 rst = 0;
    rchk(8'h19, 16'h0000);
    rchk(8'h1a, 16'h0000);
    rchk(8'h1c, 16'h0000);
    u_host.wr(8'h1b, 16'hffff);
    rchk(8'h1b, 16'h0001);
    for (int i = 0; i < 19; i++) begin
      t = 19'h00001 << i;
      u_host.wr(8'h19, t[15:0]);
      u_host.wr(8'h1a, {13'h0000, t[18:16]});
      dchk(t);
    end
    u_host.wr(8'h19, 16'hffff);
    u_host.wr(8'h1a, 16'hffff);
    rchk(8'h1a, 16'h0007);
    for (int m = 0; m < 4; m++) begin
      power_mode = open_detect_pkg::power_mode_e'(m);
      dchk(m < 2 ? 19'h7ffff : 19'h00000);
    end
    power_mode = open_detect_pkg::mode_standby;
    u_host.wr(8'h1b, 16'h0000);
    dchk(19'h00000);
    u_host.run_check(19'h40005);
    dchk(19'h00000);
    rchk(8'h1b, 16'h0000);
    `CHK("drop", 1'b1, u_host.wire_open(3700, 3600, 1'b0, 100))
    `CHK("rise", 1'b1, u_host.wire_open(3700, 3800, 1'b1, 100))
    `CHK("pair", 1'b0, u_host.wire_open(3700, 3623, 1'b0, 200))
    stop_test();
  end
endmodule : testbench
bind open_detect_ctrl open_detect_monitor u_mon (.*);
